// ---- logic/ebpsh_pin_mux.v ----
/*
  external bus pin sharing: routes the static memory controller or the
  sdram controller onto the shared address, data, strobe and select pins,
  with the documented active levels and byte-lane meanings.
  assumes both controllers present synchronous, active-high requests on
  the system clock and never request the bus together; all pin outputs
  are registered, so pins follow the inputs one clock later.
*/
// Notes on behaviour
// (R1) each shared pin follows whichever controller currently owns the bus
// (R2) sdram addr 9..0 on pins 11..2, bit 10 on own pin, 12..11 on 14..13
// (R3) static drives all address pins; sdram leaves 0,1,12,25..15 alone
// (R4) two 8-bit devices: strobe one writes upper, strobe zero lower byte
// (R5) byte-write mode: each of four strobes writes only its own lane
// (R6) byte selects 0 and 1 qualify low and high bytes of lower half
// (R7) byte selects 2 and 3 qualify low and high bytes of upper half
// (R8) 32-bit static device: byte select n enables lane n
// (R9) external wait input low means the access must be stretched
// (R10) flash chip select is driven low to select the flash
// (R11) flash output enable and write enable are active low
// (R12) sdram clock enable high keeps memory clocked, low suspends it
// (R13) sdram chip select low while the sdram controller addresses memory
// (R14) sdram write command is active low
// (R15) sdram row and column strobes are active low
// (R16) sdram clock is a complementary true and inverted pair
// (R17) static strobes and selects active low, deasserted when idle
`timescale 1ns/100ps
`include "ebpsh_regs.vh"

module ebpsh_pin_mux #(
  parameter ADDR_W = `EBPSH_ADDR_W,
  parameter DATA_W = `EBPSH_DATA_W
) (
  // clock and reset
  input  wire                 mclk_in,
  input  wire                 resetn_in,
  // static controller side
  input  wire                 static_req_in,
  input  wire                 static_write_in,
  input  wire                 static_mode_in,
  input  wire [5:0]           static_cs_in,
  input  wire [ADDR_W-1:0]    static_addr_in,
  input  wire [3:0]           static_lanes_in,
  input  wire [DATA_W-1:0]    static_wdata_in,
  output reg                  static_wait_out,
  // sdram controller side
  input  wire                 sdram_req_in,
  input  wire                 sdram_write_in,
  input  wire [12:0]          sdram_addr_in,
  input  wire [1:0]           sdram_bank_in,
  input  wire                 sdram_ras_in,
  input  wire                 sdram_cas_in,
  input  wire                 sdram_we_in,
  input  wire [3:0]           sdram_lanes_in,
  input  wire [DATA_W-1:0]    sdram_wdata_in,
  input  wire                 sdram_clock_en_in,
  input  wire                 sdram_clk_tick_in,
  // flash control from the static side
  input  wire                 flash_sel_in,
  input  wire                 flash_read_in,
  input  wire                 flash_write_in,
  // shared pins
  output reg  [ADDR_W-1:0]    addr_out,
  output reg  [DATA_W-1:0]    data_out,
  output reg                  data_oe_out,
  input  wire [DATA_W-1:0]    data_in,
  output reg  [DATA_W-1:0]    rdata_out,
  input  wire                 ext_wait_req_n_in,
  // static pins
  output reg  [5:0]           static_chip_sel_n_out,
  output reg                  read_strobe_n_out,
  output reg  [3:0]           lane_write_strobe_n_out,
  output reg  [3:0]           byte_select_n_out,
  output reg                  write_strobe_n_out,
  // flash pins
  output reg                  flash_chip_sel_n_out,
  output reg                  flash_out_en_n_out,
  output reg                  flash_wr_en_n_out,
  // sdram pins
  output wire                 sdram_clock_pair_p_out,
  output wire                 sdram_clock_pair_n_out,
  output reg                  sdram_clock_en_out,
  output reg                  sdram_chip_sel_n_out,
  output reg                  sdram_write_cmd_n_out,
  output reg                  sdram_row_strobe_n_out,
  output reg                  sdram_col_strobe_n_out,
  output reg                  sdram_addr_bit10_out,
  output reg  [1:0]           bank_select_out,
  output reg  [1:0]           owner_out
);

  ////////////////////////////////////////////////////////////////////////
  // ownership
  reg  [1:0]        owner_next;
  reg  [ADDR_W-1:0] addr_next;
  reg  [3:0]        lws_next;
  reg  [3:0]        bsel_next;

  always @* begin
    if (sdram_req_in)
      owner_next = `EBPSH_OWN_SDRAM;
    else if (static_req_in)
      owner_next = `EBPSH_OWN_STATIC;
    else
      owner_next = `EBPSH_OWN_IDLE;
  end

  ////////////////////////////////////////////////////////////////////////
  // address and byte-lane routing
  always @* begin
    addr_next = addr_out;
    lws_next  = `EBPSH_LANE_IDLE;
    bsel_next = `EBPSH_LANE_IDLE;
    case (owner_next)
      `EBPSH_OWN_STATIC: begin
        addr_next = static_addr_in; // [R3] [R1]
        if (static_mode_in == `EBPSH_MODE_BYTE_WRITE) begin
          // lane n strobe writes only lane n (two-device case uses 0/1)
          if (static_write_in)
            lws_next = ~static_lanes_in; // [R5] [R4]
        end else begin
          // selects qualify lanes; write goes on the common strobe
          bsel_next = ~static_lanes_in; // [R6] [R7] [R8]
        end
      end
      `EBPSH_OWN_SDRAM: begin
        // pins 0,1,12 and 25..15 keep their last level
        addr_next[11:2]  = sdram_addr_in[9:0];   // [R2]
        addr_next[14:13] = sdram_addr_in[12:11]; // [R2]
        bsel_next        = ~sdram_lanes_in;      // [R3] [R6] [R7]
      end
      default: begin
        addr_next = addr_out;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // registered pins
  always @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      owner_out               <= `EBPSH_OWN_IDLE;
      addr_out                <= {ADDR_W{1'b0}};
      data_out                <= {DATA_W{1'b0}};
      data_oe_out             <= 1'b0;
      rdata_out               <= {DATA_W{1'b0}};
      static_wait_out         <= 1'b0;
      static_chip_sel_n_out   <= `EBPSH_CS_IDLE;
      read_strobe_n_out       <= 1'b1;
      lane_write_strobe_n_out <= `EBPSH_LANE_IDLE;
      byte_select_n_out       <= `EBPSH_LANE_IDLE;
      write_strobe_n_out      <= 1'b1;
      flash_chip_sel_n_out    <= 1'b1;
      flash_out_en_n_out      <= 1'b1;
      flash_wr_en_n_out       <= 1'b1;
      sdram_clock_en_out      <= 1'b0;
      sdram_chip_sel_n_out    <= 1'b1;
      sdram_write_cmd_n_out   <= 1'b1;
      sdram_row_strobe_n_out  <= 1'b1;
      sdram_col_strobe_n_out  <= 1'b1;
      sdram_addr_bit10_out    <= 1'b0;
      bank_select_out         <= 2'h0;
    end else begin
      owner_out               <= owner_next; // [R1]
      addr_out                <= addr_next;
      lane_write_strobe_n_out <= lws_next;
      byte_select_n_out       <= bsel_next;
      rdata_out               <= data_in;
      // a static request refused behind sdram ownership is no access
      static_wait_out         <= (owner_next == `EBPSH_OWN_STATIC) &
                                 ~ext_wait_req_n_in; // [R9]
      sdram_clock_en_out      <= sdram_clock_en_in; // [R12]
      // static strobes: idle high unless static owns the bus [R17]
      if (owner_next == `EBPSH_OWN_STATIC) begin
        static_chip_sel_n_out <= ~static_cs_in; // [R17]
        read_strobe_n_out     <= static_write_in;
        write_strobe_n_out    <= ~static_write_in |
                                 (static_mode_in ==
                                  `EBPSH_MODE_BYTE_WRITE);
        flash_chip_sel_n_out  <= ~flash_sel_in;    // [R10]
        flash_out_en_n_out    <= ~flash_read_in;   // [R11]
        flash_wr_en_n_out     <= ~flash_write_in;  // [R11]
        data_out              <= static_wdata_in;  // [R3]
        data_oe_out           <= static_write_in;
      end else begin
        static_chip_sel_n_out <= `EBPSH_CS_IDLE;
        read_strobe_n_out     <= 1'b1;
        write_strobe_n_out    <= 1'b1;
        flash_chip_sel_n_out  <= 1'b1;
        flash_out_en_n_out    <= 1'b1;
        flash_wr_en_n_out     <= 1'b1;
        data_out              <= sdram_wdata_in;   // [R3]
        data_oe_out           <= (owner_next == `EBPSH_OWN_SDRAM) &
                                 sdram_write_in;
      end
      if (owner_next == `EBPSH_OWN_SDRAM) begin
        sdram_chip_sel_n_out   <= 1'b0;             // [R13]
        sdram_write_cmd_n_out  <= ~sdram_we_in;     // [R14]
        sdram_row_strobe_n_out <= ~sdram_ras_in;    // [R15]
        sdram_col_strobe_n_out <= ~sdram_cas_in;    // [R15]
        sdram_addr_bit10_out   <= sdram_addr_in[10]; // [R2]
        bank_select_out        <= sdram_bank_in;
      end else begin
        sdram_chip_sel_n_out   <= 1'b1;
        sdram_write_cmd_n_out  <= 1'b1;
        sdram_row_strobe_n_out <= 1'b1;
        sdram_col_strobe_n_out <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sdram clock pair
  ebpsh_sdclk_pair u_sdclk (
    .mclk_in      (mclk_in),
    .resetn_in    (resetn_in),
    .tick_in      (sdram_clk_tick_in),
    .run_in       (sdram_clock_en_in),
    .clk_true_out (sdram_clock_pair_p_out),
    .clk_inv_out  (sdram_clock_pair_n_out)
  );

endmodule

// ---- common/ebpsh_regs.vh ----
/*
  pin-sharing constants for the external bus pin mux: owner codes,
  access modes, widths, and idle levels of active-low groups.
  assumes nothing beyond a verilog-2005 compiler.
*/
`ifndef EBPSH_REGS_VH
`define EBPSH_REGS_VH

// bus owner codes
`define EBPSH_OWN_IDLE   2'h0
`define EBPSH_OWN_STATIC 2'h1
`define EBPSH_OWN_SDRAM  2'h2

// static byte-access modes
`define EBPSH_MODE_BYTE_SEL   1'h0
`define EBPSH_MODE_BYTE_WRITE 1'h1

// widths
`define EBPSH_ADDR_W   26
`define EBPSH_DATA_W   32
`define EBPSH_SDADDR_W 13
`define EBPSH_NCS      6

// idle (deasserted) level of active-low groups
`define EBPSH_CS_IDLE   6'h3f
`define EBPSH_LANE_IDLE 4'hf

`endif

// ---- logic/ebpsh_sdclk_pair.v ----
/*
  sdram clock pair generator: true and inverted outputs from registers,
  toggled on each one-cycle enable so the pair stays complementary.
  assumes a single system clock and an enable pulse from the caller.
*/
`timescale 1ns/100ps

module ebpsh_sdclk_pair (
  // clock and reset
  input  wire mclk_in,
  input  wire resetn_in,
  // control
  input  wire tick_in,
  input  wire run_in,
  // clock pair
  output reg  clk_true_out,
  output reg  clk_inv_out
);

  always @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      clk_true_out <= 1'b0;
      clk_inv_out  <= 1'b1;
    end else if (!run_in) begin
      clk_true_out <= 1'b0;
      clk_inv_out  <= 1'b1;
    end else if (tick_in) begin
      clk_true_out <= ~clk_true_out; // [R16]
      clk_inv_out  <= clk_true_out;  // [R16]
    end
  end

endmodule

// ---- test/ebpsh_pin_mux_checker.sv ----
/* timing checks on the pin mux ports: pins follow the owner one clock
   after the request. assumes one clock domain and the regs header. */
`timescale 1ns/100ps
module ebpsh_pin_mux_checker (
  // scalar ports
  input wire mclk_in, resetn_in, static_req_in, static_write_in,
  input wire static_mode_in, sdram_req_in, sdram_ras_in, sdram_cas_in,
  input wire sdram_we_in, sdram_clock_en_in, sdram_clk_tick_in,
  input wire ext_wait_req_n_in, static_wait_out, read_strobe_n_out,
  input wire write_strobe_n_out, sdram_chip_sel_n_out, sdram_clock_en_out,
  input wire sdram_row_strobe_n_out, sdram_col_strobe_n_out,
  input wire sdram_write_cmd_n_out, sdram_addr_bit10_out,
  input wire sdram_clock_pair_p_out, sdram_clock_pair_n_out,
  // vector ports
  input wire [5:0]  static_cs_in, static_chip_sel_n_out,
  input wire [3:0]  static_lanes_in, lane_write_strobe_n_out,
  input wire [3:0]  byte_select_n_out,
  input wire [25:0] static_addr_in, addr_out,
  input wire [12:0] sdram_addr_in,
  input wire [1:0]  owner_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);
  wire        st_own = static_req_in & ~sdram_req_in;
  wire [13:0] hold_bits = {addr_out[25:15], addr_out[12], addr_out[1:0]};
  wire [12:0] sd_pins = {addr_out[14:13], sdram_addr_bit10_out,
                         addr_out[11:2]};
  ////////////////////////////////////////////////////////////////////
  sdram_owner_a: assert property (sdram_req_in |=> owner_out == 2'h2
    && !sdram_chip_sel_n_out) else $error("sdram owner pins wrong");
  sdram_addr_a: assert property (sdram_req_in |=> sd_pins ==
    $past(sdram_addr_in)) else $error("sdram address routing wrong");
  addr_hold_a: assert property (sdram_req_in |=> hold_bits ==
    $past(hold_bits)) else $error("sdram touched unused address pins");
  static_addr_a: assert property (st_own |=> addr_out ==
    $past(static_addr_in)) else $error("static address wrong");
  static_cs_a: assert property (st_own |=> static_chip_sel_n_out ==
    ~$past(static_cs_in)) else $error("chip select level wrong");
  idle_pins_a: assert property (!static_req_in && !sdram_req_in |=>
    static_chip_sel_n_out == 6'h3f && read_strobe_n_out &&
    write_strobe_n_out && (lane_write_strobe_n_out & byte_select_n_out)
    == 4'hf) else $error("strobes not idle");
  byte_write_a: assert property (st_own && static_mode_in &&
    static_write_in |=> lane_write_strobe_n_out == ~$past(static_lanes_in)
    && byte_select_n_out == 4'hf) else $error("lane strobes wrong");
  byte_sel_a: assert property (st_own && !static_mode_in |=>
    byte_select_n_out == ~$past(static_lanes_in) && write_strobe_n_out
    == !$past(static_write_in)) else $error("byte selects wrong");
  sdram_cmd_a: assert property (sdram_req_in |=>
    {sdram_row_strobe_n_out, sdram_col_strobe_n_out, sdram_write_cmd_n_out}
    == ~$past({sdram_ras_in, sdram_cas_in, sdram_we_in}))
    else $error("sdram command levels wrong");
  wait_flag_a: assert property (st_own && !ext_wait_req_n_in |=>
    static_wait_out) else $error("wait not reported");
  wait_clear_a: assert property (!st_own || ext_wait_req_n_in |=>
    !static_wait_out) else $error("wait reported without a request");
  clock_pair_a: assert property (sdram_clk_tick_in && sdram_clock_en_in
    |=> sdram_clock_pair_p_out != $past(sdram_clock_pair_p_out) &&
    sdram_clock_pair_n_out == $past(sdram_clock_pair_p_out))
    else $error("clock pair did not toggle");
  clock_en_a: assert property (sdram_clock_en_out ==
    $past(sdram_clock_en_in)) else $error("clock enable wrong");
  cover property (st_own && static_mode_in && static_write_in);
  cover property (sdram_req_in && static_req_in);
  cover property (st_own && !ext_wait_req_n_in);
endmodule
bind ebpsh_pin_mux ebpsh_pin_mux_checker i_chk (.*);

// ---- test/ebpsh_ext_mem.sv ----
/* far-side memory model: word store written while the mux drives data.
   assumes the mux addresses words on address pins 5..2. */
`timescale 1ns/100ps
module ebpsh_ext_mem (
  input  wire         mclk_in,
  input  wire  [31:0] pin_d_in,
  input  wire         pin_oe_in,
  input  wire         read_n_in,
  input  wire  [25:0] addr_in,
  input  wire         stall_in,
  output logic [31:0] bus_out,
  output wire         wait_n_out
);
  logic [31:0] mem [0:15];
  // known contents so a read never hands back unknowns
  initial for (int j = 0; j < 16; j++) mem[j] = 32'h0000_0000;
  logic [31:0] last = 32'h0000_0000;
  // stretch request is a low level on the wait pin
  assign wait_n_out = !stall_in;
  // released bus shows the inverse of its last level, not a stale copy
  always_comb bus_out = pin_oe_in ? pin_d_in :
                        !read_n_in ? mem[addr_in[5:2]] : ~last;
  always @(posedge mclk_in) begin
    last <= bus_out;
    if (pin_oe_in)
      mem[addr_in[5:2]] <= pin_d_in;
  end
endmodule

// ---- test/ebpsh_pin_mux_bench.sv ----
/* self-checking bench for the pin mux: reset levels, then random owner,
   mode and field mix with each owner case forced first.
   assumes the regs header on the include path. */
`timescale 1ns/100ps
`include "ebpsh_regs.vh"
module ebpsh_pin_mux_bench;
  reg         mclk_in = 0, resetn_in = 0, static_req_in = 0, stall = 0;
  reg         static_write_in = 0, static_mode_in = 0, sdram_req_in = 0;
  reg         sdram_write_in = 0, sdram_ras_in = 0, sdram_cas_in = 0;
  reg         sdram_we_in = 0, sdram_clock_en_in = 0, sdram_clk_tick_in = 0;
  reg         flash_sel_in = 0, flash_read_in = 0, flash_write_in = 0;
  reg  [5:0]  static_cs_in = 0;
  reg  [25:0] static_addr_in = 0;
  reg  [3:0]  static_lanes_in = 0, sdram_lanes_in = 0;
  reg  [31:0] static_wdata_in = 0, sdram_wdata_in = 0, r = 32'h31f7_7d0e;
  reg  [12:0] sdram_addr_in = 0;
  reg  [1:0]  sdram_bank_in = 0, k;
  wire        static_wait_out, data_oe_out, ext_wait_req_n_in;
  wire        read_strobe_n_out, write_strobe_n_out, flash_chip_sel_n_out;
  wire        flash_out_en_n_out, flash_wr_en_n_out, sdram_clock_en_out;
  wire        sdram_clock_pair_p_out, sdram_clock_pair_n_out;
  wire        sdram_chip_sel_n_out, sdram_write_cmd_n_out;
  wire        sdram_row_strobe_n_out, sdram_col_strobe_n_out;
  wire        sdram_addr_bit10_out;
  wire [25:0] addr_out;
  wire [31:0] data_out, data_in, rdata_out;
  wire [5:0]  static_chip_sel_n_out;
  wire [3:0]  lane_write_strobe_n_out, byte_select_n_out;
  wire [1:0]  bank_select_out, owner_out;
  wire [8:0]  st_pins = {lane_write_strobe_n_out, byte_select_n_out,
                         write_strobe_n_out};
  wire [1:0]  fl_pins = {flash_out_en_n_out, flash_wr_en_n_out};
  wire [2:0]  sd_cmd = {sdram_row_strobe_n_out, sdram_col_strobe_n_out,
                        sdram_write_cmd_n_out};
  wire [12:0] sd_pins = {addr_out[14:13], sdram_addr_bit10_out,
                         addr_out[11:2]};
  wire [2:0]  sd_cmd_in = {sdram_ras_in, sdram_cas_in, sdram_we_in};
  wire [15:0] st_all = {static_chip_sel_n_out, read_strobe_n_out, st_pins};
  reg  [31:0] d_seen = 32'h0000_0000;
  int         num_errors = 0, total_checks = 0, cyc = 0, i;
  always #50 mclk_in = ~mclk_in;
  ebpsh_pin_mux i_dut (.*);
  ebpsh_ext_mem i_mem (.mclk_in(mclk_in), .pin_d_in(data_out),
    .pin_oe_in(data_oe_out), .read_n_in(read_strobe_n_out),
    .addr_in(addr_out), .stall_in(stall), .bus_out(data_in),
    .wait_n_out(ext_wait_req_n_in));
  ////////////////////////////////////////////////////////////////////
  function [31:0] lfsr(input [31:0] x);
    lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // lane strobes, byte selects, write strobe for a static access
  function [8:0] exp_st(input m, input w, input [3:0] l);
    exp_st = m ? {w ? ~l : 4'hf, 4'hf, 1'h1} : {4'hf, ~l, ~w};
  endfunction
  wire [8:0]  st_exp = exp_st(static_mode_in, static_write_in,
                              static_lanes_in);
  task chk(input [31:0] g, input [31:0] e);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("Error at %0t: got %h, expected %h", $time, g, e);
    end
  endtask
  task close_out;
    $display("checks %0d, mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      close_out;
    end
  end
  ////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge mclk_in);
    #1;
    chk(static_chip_sel_n_out, 6'h3f);
    chk({sd_cmd, sdram_chip_sel_n_out}, 4'hf);
    chk({sdram_clock_pair_p_out, sdram_clock_pair_n_out}, 2'h1);
    chk(sdram_clock_en_out, 1'h0);
    $display("reset level test done");
    repeat (4) @(posedge mclk_in);
    resetn_in <= 1;
    for (i = 0; i < 400; i++) begin
      @(posedge mclk_in);
      r = lfsr(r);
      k = i < 4 ? i[1:0] : r[1:0];
      static_req_in <= k[0];
      sdram_req_in <= k[1];
      {static_write_in, static_mode_in, sdram_ras_in, sdram_cas_in,
       sdram_we_in, flash_sel_in, flash_read_in, flash_write_in, stall,
       sdram_clock_en_in, sdram_clk_tick_in, sdram_write_in} <= r[13:2];
      static_cs_in <= r[19:14];
      static_lanes_in <= r[23:20];
      sdram_lanes_in <= r[27:24];
      r = lfsr(r);
      static_addr_in <= r[25:0];
      sdram_addr_in <= r[31:19];
      sdram_bank_in <= r[1:0];
      static_wdata_in <= r;
      sdram_wdata_in <= ~r;
      #1;
      if (i > 0)
        chk(rdata_out, d_seen);
      @(posedge mclk_in);
      #1;
      chk(owner_out, k[1] ? 2'h2 : {1'h0, k[0]});
      chk(static_wait_out, k == 2'h1 && stall);
      chk(sdram_chip_sel_n_out, !k[1]);
      chk(sdram_clock_en_out, sdram_clock_en_in);
      chk(sdram_clock_pair_p_out, !sdram_clock_pair_n_out);
      if (k == 2'h0)
        chk(st_all, 16'hffff);
      if (k == 2'h1) begin
        chk(addr_out, static_addr_in);
        chk(st_pins, st_exp);
        chk(static_chip_sel_n_out, {~static_cs_in});
        chk(read_strobe_n_out, static_write_in);
        chk(data_out, static_wdata_in);
        chk(data_oe_out, static_write_in);
        chk(flash_chip_sel_n_out, !flash_sel_in);
        if (flash_sel_in)
          chk(fl_pins, {~{flash_read_in, flash_write_in}});
      end
      if (k[1]) begin
        chk(sd_pins, sdram_addr_in);
        chk(sd_cmd, {~sd_cmd_in});
        chk(st_pins, {4'hf, ~sdram_lanes_in, 1'h1});
        chk(data_out, sdram_wdata_in);
        chk(data_oe_out, sdram_write_in);
        chk(bank_select_out, sdram_bank_in);
      end
      d_seen = data_in;
    end
    $display("random sharing test done");
    close_out;
  end
endmodule
